// *** logic/rhs_ms_tick.v ***
// Millisecond enable pulse divider
`timescale 1ns/10ps
`include "rhs_seq_map.vh"
module rhs_ms_tick #(
  parameter CYC_PER_MS = `RHS_CYC_PER_MS
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire clear_in,
  output reg tick_out
);
  reg [`RHS_PRE_W-1:0] pre_r;
  localparam [`RHS_PRE_W-1:0] LAST = CYC_PER_MS - 1;
  // Count cycles, pulse once per millisecond; clear restarts the phase
  always @(posedge ref_clk_in) begin
    if (!rstn_in || clear_in) begin
      pre_r <= {`RHS_PRE_W{1'b0}};
      tick_out <= 1'b0;
    end else if (pre_r == LAST) begin
      pre_r <= {`RHS_PRE_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      pre_r <= pre_r + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule // rhs_ms_tick

// *** logic/rhs_seq_map.vh ***
// Timing constants and counter widths for the reset and hibernate sequencer
`ifndef RHS_SEQ_MAP_VH
`define RHS_SEQ_MAP_VH
// Core clock rate in kHz (250 MHz)
`define RHS_CLK_KHZ 250000
// Hardware wake-up after restart release, ms
`define RHS_HW_WAKE_MS 25
// Initialization with on-chip slow crystal, ms (1.35 s)
`define RHS_INIT_XTAL_MS 1350
// Initialization with external slow clock, ms
`define RHS_INIT_EXT_MS 250
// Wake from hibernate, ms
`define RHS_HIB_WAKE_MS 50
// Extra wake time after large temperature shift, ms
`define RHS_TEMP_EXTRA_MS 200
// Temperature shift above which recalibration is forced, degrees C
`define RHS_TEMP_LIMIT_C 20
// Slow clock rate in Hz and fast clock rate in kHz
`define RHS_SLOW_HZ 32768
`define RHS_FAST_KHZ 40000
// Cycles per millisecond at the core clock
`define RHS_CYC_PER_MS (`RHS_CLK_KHZ)
// Width of the millisecond countdown
`define RHS_MS_W 11
// Width of the cycle prescaler
`define RHS_PRE_W 18
`endif

// *** logic/rhs_sequencer.v ***
// Device-side reset and hibernate wake-up sequencer
`timescale 1ns/10ps
`include "rhs_seq_map.vh"
module rhs_sequencer #(
  parameter CYC_PER_MS = `RHS_CYC_PER_MS
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire device_restart_n_in,
  input wire sleep_request_n_in,
  input wire ext_slow_clk_sel_in,
  input wire slow_xtal_keep_off_in,
  input wire [7:0] temp_c_in,
  output reg ready_out,
  output reg slow_osc_en_out,
  output reg fast_osc_en_out,
  output reg hibernate_out,
  output reg recal_out,
  output reg [4:0] state_out
);
  // One-hot states
  localparam [4:0] ST_RESET = 5'h01;
  localparam [4:0] ST_HWAKE = 5'h02;
  localparam [4:0] ST_INIT = 5'h04;
  localparam [4:0] ST_READY = 5'h08;
  localparam [4:0] ST_HIB = 5'h10;
  localparam [`RHS_MS_W-1:0] HW_MS = `RHS_HW_WAKE_MS;
  localparam [`RHS_MS_W-1:0] XT_MS = `RHS_INIT_XTAL_MS;
  localparam [`RHS_MS_W-1:0] EX_MS = `RHS_INIT_EXT_MS;
  localparam [`RHS_MS_W-1:0] HB_MS = `RHS_HIB_WAKE_MS;
  localparam [`RHS_MS_W-1:0] TX_MS = `RHS_TEMP_EXTRA_MS;
  localparam [7:0] TLIM = `RHS_TEMP_LIMIT_C;

  reg rst_m_r, rst_s_r, hib_m_r, hib_s_r, sel_m_r, sel_s_r;
  reg keep_m_r, keep_s_r;
  reg [7:0] temp_m_r, temp_s_r, temp_hib_r;
  reg [4:0] st_r, st_nxt;
  reg [`RHS_MS_W-1:0] cnt_r, cnt_nxt;
  reg ext_r, ext_nxt, recal_r, recal_nxt;
  reg [7:0] temp_hib_nxt;
  reg [7:0] tdiff;
  wire tick;
  wire restart;

  // Two-flop synchronisers for pins arriving from the host side
  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
      hib_m_r <= 1'b1;
      hib_s_r <= 1'b1;
      sel_m_r <= 1'b0;
      sel_s_r <= 1'b0;
      keep_m_r <= 1'b0;
      keep_s_r <= 1'b0;
      temp_m_r <= 8'h00;
      temp_s_r <= 8'h00;
    end else begin
      rst_m_r <= device_restart_n_in;
      rst_s_r <= rst_m_r;
      hib_m_r <= sleep_request_n_in;
      hib_s_r <= hib_m_r;
      sel_m_r <= ext_slow_clk_sel_in;
      sel_s_r <= sel_m_r;
      keep_m_r <= slow_xtal_keep_off_in;
      keep_s_r <= keep_m_r;
      temp_m_r <= temp_c_in;
      temp_s_r <= temp_m_r;
    end
  end

  // Restart low overrides every state; the host keeps it low while rails ramp
  // restart holds reset
  assign restart = ~rst_s_r;

  // Millisecond tick, rephased on each state change
  rhs_ms_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .clear_in(st_nxt != st_r),
    .tick_out(tick)
  );

  // Absolute temperature shift since hibernate entry
  always @* begin
    if (temp_s_r > temp_hib_r)
      tdiff = temp_s_r - temp_hib_r;
    else
      tdiff = temp_hib_r - temp_s_r;
  end

  // Next-state logic
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ext_nxt = ext_r;
    recal_nxt = recal_r;
    temp_hib_nxt = temp_hib_r;
    if (restart) begin
      st_nxt = ST_RESET;
      cnt_nxt = HW_MS;
      recal_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_RESET: begin
          ext_nxt = sel_s_r;
          st_nxt = ST_HWAKE;
          cnt_nxt = HW_MS;
        end
        ST_HWAKE: begin
          if (tick) begin
            if (cnt_r == 1) begin
              st_nxt = ST_INIT;
              cnt_nxt = ext_r ? EX_MS : XT_MS;
            end else begin
              cnt_nxt = cnt_r - 1'b1;
            end
          end
        end
        ST_INIT: begin
          if (tick) begin
            if (cnt_r == 1)
              st_nxt = ST_READY;
            else
              cnt_nxt = cnt_r - 1'b1;
          end
        end
        ST_READY: begin
          if (!hib_s_r) begin
            st_nxt = ST_HIB;
            temp_hib_nxt = temp_s_r;
          end
        end
        ST_HIB: begin
          if (hib_s_r) begin
            st_nxt = ST_INIT;
            recal_nxt = (tdiff > TLIM);
            cnt_nxt = (tdiff > TLIM) ? HB_MS + TX_MS : HB_MS;
          end
        end
        default: begin
          st_nxt = ST_RESET;
        end
      endcase
    end
  end

  // State registers
  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_r <= ST_RESET;
      cnt_r <= HW_MS;
      ext_r <= 1'b0;
      recal_r <= 1'b0;
      temp_hib_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ext_r <= ext_nxt;
      recal_r <= recal_nxt;
      temp_hib_r <= temp_hib_nxt;
    end
  end

  // Registered outputs
  always @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ready_out <= 1'b0;
      slow_osc_en_out <= 1'b0;
      fast_osc_en_out <= 1'b0;
      hibernate_out <= 1'b0;
      recal_out <= 1'b0;
      state_out <= ST_RESET;
    end else begin
      ready_out <= (st_nxt == ST_READY);
      slow_osc_en_out <= (st_nxt != ST_RESET) &&
        !((st_nxt == ST_HIB) && keep_s_r) && !ext_nxt;
      fast_osc_en_out <= (st_nxt != ST_RESET) && (st_nxt != ST_HIB);
      hibernate_out <= (st_nxt == ST_HIB);
      recal_out <= recal_nxt && (st_nxt == ST_INIT);
      state_out <= st_nxt;
    end
  end
endmodule // rhs_sequencer

// *** verification/rhs_host_model.sv ***
// Host model driving the restart and hibernate pins
`timescale 1ns/10ps
module rhs_host_model #(parameter MIN_HIB = 40) (
  input wire ref_clk_in,
  input wire restart_req_in,
  input wire sleep_req_in,
  output wire device_restart_n_out,
  output wire sleep_request_n_out
);
  reg [7:0] hib_cnt_r = 8'h00;
  always @(posedge ref_clk_in) begin
    hib_cnt_r <= sleep_request_n_out ? 8'h00 : hib_cnt_r + 8'h01;
  end
  assign sleep_request_n_out = !(sleep_req_in ||
    (hib_cnt_r != 8'h00 && hib_cnt_r < MIN_HIB));
  // pulldown fitted, so a short pulse suffices
  assign device_restart_n_out = !restart_req_in;
endmodule // rhs_host_model

// *** verification/rhs_seq_monitor.sv ***
// Port assertions for the sequencer
`timescale 1ns/10ps
module rhs_seq_monitor #(parameter CYC_PER_MS = 4) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire device_restart_n_in,
  input wire sleep_request_n_in,
  input wire ext_slow_clk_sel_in,
  input wire slow_xtal_keep_off_in,
  input wire ready_out,
  input wire slow_osc_en_out,
  input wire fast_osc_en_out,
  input wire hibernate_out,
  input wire recal_out,
  input wire [4:0] state_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Wake and init spans at four cycles a millisecond
  sequence s_hw_wake;
    ##[95:105] (state_out == 5'h04);
  endsequence
  // Cycles spent in the init state, saturating; too long for a delay range
  reg [10:0] init_cyc_r = 11'h000;
  always @(posedge ref_clk_in) begin
    if (!rstn_in || state_out != 5'h04)
      init_cyc_r <= 11'h000;
    else if (init_cyc_r != 11'h7ff)
      init_cyc_r <= init_cyc_r + 11'h001;
  end
  // High when the current wake began at a restart, not at hibernate exit
  reg from_restart_r = 1'b0;
  always @(posedge ref_clk_in) begin
    if (!rstn_in || state_out == 5'h10)
      from_restart_r <= 1'b0;
    else if (state_out == 5'h02)
      from_restart_r <= 1'b1;
  end
  // Ready arrives about 1000 cycles into init
  sequence s_init_ext;
    init_cyc_r >= 11'h3de && init_cyc_r <= 11'h3f2;
  endsequence
  sequence s_recal_len;
    init_cyc_r >= 11'h3d9 && init_cyc_r <= 11'h3f2;
  endsequence
  chk_hw_wake: assert property ($rose(state_out == 5'h02) &&
    $past(state_out) == 5'h01 |-> s_hw_wake) else $error("hw wake off");
  chk_init_ext: assert property ($rose(ready_out) &&
    ext_slow_clk_sel_in && from_restart_r |-> s_init_ext)
    else $error("ext init off");
  chk_ext_osc: assert property (ready_out &&
    ext_slow_clk_sel_in |-> !slow_osc_en_out) else $error("xtal on");
  chk_hib_osc: assert property (hibernate_out &&
    !slow_xtal_keep_off_in && !ext_slow_clk_sel_in |-> slow_osc_en_out)
    else $error("xtal off in hibernate");
  chk_hib_entry: assert property ($fell(sleep_request_n_in) &&
    ready_out |-> ##[2:4] hibernate_out) else $error("no hibernate");
  chk_recal_wake: assert property ($rose(ready_out) &&
    $past(recal_out) |-> s_recal_len) else $error("recal wake off");
  chk_fast_osc: assert property (ready_out
    |-> fast_osc_en_out) else $error("fast osc off");
  chk_restart_drop: assert property (!device_restart_n_in
    |-> ##[1:4] !ready_out) else $error("ready kept");
endmodule // rhs_seq_monitor
bind rhs_sequencer rhs_seq_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (.*);

// *** verification/tb_rhs_sequencer.sv ***
// Self-checking bench for the sequencer
`timescale 1ns/10ps
module tb_rhs_sequencer;
  reg clk = 1'b0, rstn = 1'b0, rst_req = 1'b1, hib_req = 1'b0, ext = 1'b0;
  reg [7:0] temp = 8'h19;
  reg keep = 1'b0;
  wire rst_n, hib_n, rdy, sosc, fosc, hib, recal;
  wire [4:0] st;
  integer n_mismatch = 0, checked = 0, n;
  rhs_host_model u_host (.ref_clk_in(clk), .restart_req_in(rst_req),
    .sleep_req_in(hib_req), .device_restart_n_out(rst_n),
    .sleep_request_n_out(hib_n));
  rhs_sequencer #(.CYC_PER_MS(4)) u_dut (.ref_clk_in(clk), .rstn_in(rstn),
    .device_restart_n_in(rst_n), .sleep_request_n_in(hib_n),
    .ext_slow_clk_sel_in(ext), .slow_xtal_keep_off_in(keep),
    .temp_c_in(temp), .ready_out(rdy), .slow_osc_en_out(sosc),
    .fast_osc_en_out(fosc), .hibernate_out(hib), .recal_out(recal),
    .state_out(st));
  initial forever #2 clk = ~clk;
  task chk(input string nm, input [31:0] seen, exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Count cycles until ready, bounded
  // no traffic before ready
  task wait_rdy;
    n = 0;
    while (rdy !== 1'b1 && n < 7000) begin
      cyc(1);
      n = n + 1;
    end
  endtask
  // Restart with a slow clock choice, then time the boot
  task t_boot(input x, input integer lo, hi);
    // host is idle and stopped before the pin restart
    rst_req = 1'b1;
    cyc(4);
    chk("rdy", rdy, 0);
    // slow clock choice settles before release
    ext = x;
    cyc(4);
    rst_req = 1'b0;
    wait_rdy;
    chk("boot", n >= lo && n <= hi, 1);
    chk("osc", {fosc, sosc}, {1'b1, !x});
    chk("st", st, 5'h08);
    $display("boot test done");
  endtask
  // Hibernate, shift temperature, time the wake
  task t_hib(input [7:0] t, input integer lo, hi, input k);
    temp = 8'h19;
    keep = k;
    cyc(4);
    hib_req = 1'b1;
    cyc(44);
    chk("hib", {hib, sosc, rdy}, {1'b1, !k, 1'b0});
    chk("st", st, 5'h10);
    temp = t;
    hib_req = 1'b0;
    cyc(6);
    chk("recal", recal, t > 8'h2d);
    wait_rdy;
    chk("wake", n + 6 >= lo && n + 6 <= hi, 1);
    $display("hibernate test done");
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // restart held through reset, released later
  initial begin
    cyc(8);
    rstn = 1'b1;
    t_boot(1'b0, 5500, 5512);
    t_hib(8'h2d, 200, 212, 1'b0);
    t_hib(8'h2e, 1000, 1012, 1'b0);
    t_hib(8'h19, 200, 212, 1'b1);
    t_boot(1'b1, 1100, 1112);
    results;
  end
  // Cut a hang short
  initial begin
    #60000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule // tb_rhs_sequencer
